// [design/epis_top.sv]
/*
 * External pin interrupt sense: two dedicated lines and sixteen change-watch pins, APB register slave.
 * Assumes an APB master on mclk_i and raw asynchronous pins; the core acknowledges handler entry.
 */
`timescale 1ns/1ps
`include "epis_regs.svh"

module epis_top (
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [1:0]  ext_lines_i,
    input  wire logic [15:0] change_watch_pins_i,
    input  wire logic [3:0]  irq_ack_i,
    output logic      [3:0]  irq_req_o,
    output logic      [15:0] irq_vector_o,
    output logic             wake_o
);
    typedef struct packed {
        logic [3:0]  sense;
        logic [1:0]  line_en;
        logic [1:0]  line_flag;
        logic [1:0]  chg_en;
        logic [1:0]  chg_flag;
        logic [7:0]  mask_upper;
        logic [7:0]  mask_lower;
        logic        global_en;
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic [15:0] pin_prev;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic [3:0]  req;
        logic [15:0] vector;
        logic        wake;
        epis_pkg::epis_apb_state_t apb;
    } epis_state_t;

    epis_state_t st_r;
    epis_state_t st_nxt;
    epis_edge_if eif ();

    assign eif.lines = ext_lines_i;
    assign eif.sense = st_r.sense;

    epis_edge_det u_det (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .eif      (eif)
    );

    // ==========================================================================
    // Unclocked wake path
    // ==========================================================================
    // Changes latch a reference-free toggle: pin differs from the third-stage clocked sample pin_prev, one older than pin_s2
    logic [15:0] chg_async;
    logic [1:0]  lvl_async;
    always_comb begin
        chg_async = (change_watch_pins_i ^ st_r.pin_prev) & {st_r.mask_upper, st_r.mask_lower};
        for (int i = 0; i < 2; i++) begin
            lvl_async[i] = st_r.line_en[i] & (st_r.sense[2*i +: 2] == 2'b00) & ~ext_lines_i[i];
        end
    end
    // Combinational wake request; registered copy drives the port
    logic wake_async;
    assign wake_async = (|(chg_async[15:8]) & st_r.chg_en[1]) | (|(chg_async[7:0]) & st_r.chg_en[0])
                      | (|lvl_async);

    // ==========================================================================
    // Next state
    // ==========================================================================
    logic [15:0] toggled;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic [31:0] rd_val;
    logic [1:0]  line_set;
    logic [1:0]  chg_set;
    logic [1:0]  line_clr;
    logic [1:0]  chg_clr;
    logic [1:0]  line_irq;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.pin_s1   = change_watch_pins_i;
        st_nxt.pin_s2   = st_r.pin_s1;
        st_nxt.pin_prev = st_r.pin_s2;
        toggled = (st_r.pin_s2 ^ st_r.pin_prev) & {st_r.mask_upper, st_r.mask_lower};
        chg_set = {|toggled[15:8], |toggled[7:0]};
        line_set = eif.edge_hit;

        wr_acc = psel_i & penable_i & pwrite_i & (st_r.apb == epis_pkg::EPIS_APB_ACCESS);
        rd_acc = psel_i & penable_i & ~pwrite_i & (st_r.apb == epis_pkg::EPIS_APB_ACCESS);
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr_i)
            `EPIS_OFS_SENSE:      rd_val = {28'h0000000, st_r.sense};
            `EPIS_OFS_LINE_EN:    rd_val = {30'h0, st_r.line_en};
            `EPIS_OFS_LINE_FLAG:  rd_val = {30'h0, st_r.line_flag};
            `EPIS_OFS_CHG_EN:     rd_val = {30'h0, st_r.chg_en};
            `EPIS_OFS_CHG_FLAG:   rd_val = {30'h0, st_r.chg_flag};
            `EPIS_OFS_MASK_UPPER: rd_val = {24'h000000, st_r.mask_upper};
            `EPIS_OFS_MASK_LOWER: rd_val = {24'h000000, st_r.mask_lower};
            `EPIS_OFS_GLOBAL:     rd_val = {31'h0, st_r.global_en};
            `EPIS_OFS_PIN_STATE:  rd_val = {14'h0, eif.line_sync, st_r.pin_s2};
            default:              hit = 1'b0;
        endcase

        line_clr = {irq_ack_i[1], irq_ack_i[0]};
        chg_clr  = {irq_ack_i[3], irq_ack_i[2]};
        if (wr_acc && hit) begin
            case (paddr_i)
                `EPIS_OFS_SENSE:      st_nxt.sense = pwdata_i[3:0];
                `EPIS_OFS_LINE_EN:    st_nxt.line_en = pwdata_i[1:0];
                `EPIS_OFS_LINE_FLAG:  line_clr = line_clr | pwdata_i[1:0];
                `EPIS_OFS_CHG_EN:     st_nxt.chg_en = pwdata_i[1:0];
                `EPIS_OFS_CHG_FLAG:   chg_clr = chg_clr | pwdata_i[1:0];
                `EPIS_OFS_MASK_UPPER: st_nxt.mask_upper = pwdata_i[7:0];
                `EPIS_OFS_MASK_LOWER: st_nxt.mask_lower = pwdata_i[7:0];
                `EPIS_OFS_GLOBAL:     st_nxt.global_en = pwdata_i[0];
                default:              st_nxt.global_en = st_r.global_en;
            endcase
        end

        // Set wins over clear
        st_nxt.line_flag = (st_r.line_flag & ~line_clr) | line_set;
        st_nxt.chg_flag  = (st_r.chg_flag & ~chg_clr) | chg_set;
        for (int i = 0; i < 2; i++) begin
            if (st_r.sense[2*i +: 2] == 2'b00) begin
                st_nxt.line_flag[i] = 1'b0;
            end
        end

        // Level request follows the synchronised pin, with no flag
        for (int i = 0; i < 2; i++) begin
            line_irq[i] = (st_r.line_flag[i] | eif.level_hit[i]) & st_r.line_en[i] & st_r.global_en;
        end
        st_nxt.req = {st_r.chg_flag & st_r.chg_en & {2{st_r.global_en}}, line_irq};

        // Fixed priority: lowest vector first
        if (st_nxt.req[0]) begin
            st_nxt.vector = `EPIS_VEC_LINE_A;
        end else if (st_nxt.req[1]) begin
            st_nxt.vector = `EPIS_VEC_LINE_B;
        end else if (st_nxt.req[2]) begin
            st_nxt.vector = `EPIS_VEC_CHG_LOWER;
        end else if (st_nxt.req[3]) begin
            st_nxt.vector = `EPIS_VEC_CHG_UPPER;
        end else begin
            st_nxt.vector = 16'h0000;
        end
        st_nxt.wake = wake_async;

        // APB slave: one wait-free access phase
        st_nxt.ready  = 1'b0;
        st_nxt.slverr = 1'b0;
        case (st_r.apb)
            epis_pkg::EPIS_APB_IDLE: begin
                if (psel_i && !penable_i) begin
                    st_nxt.apb    = epis_pkg::EPIS_APB_ACCESS;
                    st_nxt.ready  = 1'b1;
                    st_nxt.slverr = ~hit;
                    st_nxt.rdata  = pwrite_i ? 32'h0000_0000 : rd_val;
                end
            end
            epis_pkg::EPIS_APB_ACCESS: begin
                st_nxt.apb = epis_pkg::EPIS_APB_IDLE;
                if (!(wr_acc || rd_acc)) begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            end
            default: st_nxt.apb = epis_pkg::EPIS_APB_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '{sense: `EPIS_SENSE_RST, line_en: `EPIS_EN_RST, line_flag: 2'h0, chg_en: `EPIS_EN_RST,
                      chg_flag: 2'h0, mask_upper: `EPIS_MASK_RST, mask_lower: `EPIS_MASK_RST,
                      global_en: 1'b0, pin_s1: 16'h0000, pin_s2: 16'h0000, pin_prev: 16'h0000,
                      rdata: 32'h0000_0000, ready: 1'b0, slverr: 1'b0, req: 4'h0, vector: 16'h0000,
                      wake: 1'b0, apb: epis_pkg::EPIS_APB_IDLE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata_o     = st_r.rdata;
    assign pready_o     = st_r.ready;
    assign pslverr_o    = st_r.slverr;
    assign irq_req_o    = st_r.req;
    assign irq_vector_o = st_r.vector;
    assign wake_o       = st_r.wake;

    // ==========================================================================
    // Checks
    // ==========================================================================
    a_gate_enable: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        irq_req_o[0] |-> $past(st_r.global_en) && $past(st_r.line_en[0]))
        else $error("line a request without both enables");
    a_level_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.sense[1:0] == 2'b00) |=> !st_r.line_flag[0])
        else $error("line a flag set in level mode");
    a_mask_block: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.mask_lower == 8'h00 && !st_r.chg_flag[0]) |=> !st_r.chg_flag[0])
        else $error("lower flag set with all pins masked");
    a_toggle_flag: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (|((st_r.pin_s2[15:8] ^ st_r.pin_prev[15:8]) & st_r.mask_upper)) |=> st_r.chg_flag[1])
        else $error("upper toggle did not set flag");
    a_level_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.global_en && st_r.line_en[1] && st_r.sense[3:2] == 2'b00 && !eif.line_sync[1]) |=> irq_req_o[1])
        else $error("held low level not requested");
    a_sense_rsvd: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (pready_o && $past(paddr_i) == `EPIS_OFS_SENSE) |-> prdata_o[31:4] == 28'h0000000)
        else $error("sense upper bits not zero");
    a_vector_map: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (irq_req_o == 4'b0100) |-> irq_vector_o == 16'h0006)
        else $error("lower group vector wrong");
    a_ready_one: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (psel_i && !penable_i && st_r.apb == epis_pkg::EPIS_APB_IDLE) |=> pready_o ##1 !pready_o)
        else $error("ready not a single cycle after setup");

endmodule : epis_top

// [inc/epis_regs.svh]
/*
 * Register offsets, field positions and reset values of the external pin interrupt sense block.
 * Assumes APB byte addressing with one aligned 32-bit word per register.
 */
`ifndef EPIS_REGS_SVH
`define EPIS_REGS_SVH

// ==========================================================================
// Offsets
// ==========================================================================
`define EPIS_OFS_SENSE      12'h000
`define EPIS_OFS_LINE_EN    12'h004
`define EPIS_OFS_LINE_FLAG  12'h008
`define EPIS_OFS_CHG_EN     12'h00c
`define EPIS_OFS_CHG_FLAG   12'h010
`define EPIS_OFS_MASK_UPPER 12'h014
`define EPIS_OFS_MASK_LOWER 12'h018
`define EPIS_OFS_GLOBAL     12'h01c
`define EPIS_OFS_PIN_STATE  12'h020

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define EPIS_SENSE_A_LSB    0
`define EPIS_SENSE_B_LSB    2
`define EPIS_SENSE_RST      4'h0
`define EPIS_MASK_RST       8'h00
`define EPIS_EN_RST         2'h0

// Vector word addresses, two words apart
`define EPIS_VEC_LINE_A     16'h0002
`define EPIS_VEC_LINE_B     16'h0004
`define EPIS_VEC_CHG_LOWER  16'h0006
`define EPIS_VEC_CHG_UPPER  16'h0008

`endif

// [inc/epis_pkg.sv]
/*
 * Types of the external pin interrupt sense block.
 * Assumes epis_regs.svh supplies the numeric constants.
 */
package epis_pkg;

    typedef enum logic [1:0] {
        EPIS_LOW_LEVEL = 2'b00,
        EPIS_ANY_EDGE  = 2'b01,
        EPIS_FALL_EDGE = 2'b10,
        EPIS_RISE_EDGE = 2'b11
    } epis_sense_t;

    typedef enum logic [1:0] {
        EPIS_APB_IDLE   = 2'b00,
        EPIS_APB_ACCESS = 2'b01
    } epis_apb_state_t;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic [1:0] pulse;
    } epis_edge_state_t;

endpackage : epis_pkg

// [inc/epis_edge_if.sv]
/*
 * Interface carrying the dedicated-line samples and decoded requests between the top and the detector.
 * Assumes one clock domain, that of the top module.
 */
`timescale 1ns/1ps
interface epis_edge_if;
    logic [1:0]              lines;
    logic [3:0]              sense;
    logic [1:0]              edge_hit;
    logic [1:0]              level_hit;
    logic [1:0]              line_sync;

    modport top (output lines, output sense, input edge_hit, input level_hit, input line_sync);
    modport det (input lines, input sense, output edge_hit, output level_hit, output line_sync);
endinterface : epis_edge_if

// [design/epis_edge_det.sv]
/*
 * Clocked edge and level detector for the two dedicated interrupt lines.
 * Assumes raw pin levels from outside the clock domain; they pass two flip-flops first.
 */
`timescale 1ns/1ps
module epis_edge_det (
    input  wire logic         mclk_i,
    input  wire logic         arst_n_i,
    epis_edge_if.det          eif
);
    epis_pkg::epis_edge_state_t st_r;
    epis_pkg::epis_edge_state_t st_nxt;

    // ==========================================================================
    // Detection
    // ==========================================================================
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = eif.lines;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev  = st_r.sync2;
        for (int i = 0; i < 2; i++) begin
            case (epis_pkg::epis_sense_t'(eif.sense[2*i +: 2]))
                epis_pkg::EPIS_ANY_EDGE:  st_nxt.pulse[i] = st_r.sync2[i] ^ st_r.prev[i];
                epis_pkg::EPIS_FALL_EDGE: st_nxt.pulse[i] = st_r.prev[i] & ~st_r.sync2[i];
                epis_pkg::EPIS_RISE_EDGE: st_nxt.pulse[i] = ~st_r.prev[i] & st_r.sync2[i];
                default:                  st_nxt.pulse[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '{sync1: 2'b11, sync2: 2'b11, prev: 2'b11, pulse: 2'b00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign eif.edge_hit  = st_r.pulse;
    assign eif.line_sync = st_r.sync2;

    // Level sensing is the synchronised low level in low-level mode
    for (genvar g = 0; g < 2; g++) begin : g_lvl
        assign eif.level_hit[g] = (eif.sense[2*g +: 2] == 2'b00) & ~st_r.sync2[g];
    end

    a_rise_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (eif.sense[1:0] == 2'b11 && $stable(eif.sense) && !st_r.prev[0] && st_r.sync2[0]) |=> eif.edge_hit[0])
        else $error("rising edge on line a gave no pulse");
    a_fall_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (eif.sense[3:2] == 2'b10 && $stable(eif.sense) && st_r.prev[1] && !st_r.sync2[1]) |=> eif.edge_hit[1])
        else $error("falling edge on line b gave no pulse");
    a_single_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        eif.edge_hit[0] |=> !eif.edge_hit[0])
        else $error("edge pulse lasted more than one cycle");

endmodule : epis_edge_det

// [verif/epis_pin_model.sv]
/*
 * Far-side model: the external sources driving the two dedicated lines and the change-watch pins.
 * Assumes the bench calls its tasks one at a time; outputs change only after a rising edge.
 */
`timescale 1ns/1ps
module epis_pin_model (
    input  wire logic        mclk_i,
    output logic      [1:0]  ext_lines_o,
    output logic      [15:0] change_watch_pins_o
);
    localparam int HOLD = 3;

    initial begin
        ext_lines_o         = 2'b11;
        change_watch_pins_o = 16'h0000;
    end

    // Level held several clocks so it outlives sampling and any instruction in flight
    task automatic set_line(input int i, input logic v);
        @(posedge mclk_i);
        ext_lines_o[i] <= v;
        repeat (HOLD) @(posedge mclk_i);
    endtask : set_line

    task automatic toggle_pin(input int i);
        @(posedge mclk_i);
        change_watch_pins_o[i] <= ~change_watch_pins_o[i];
        repeat (HOLD) @(posedge mclk_i);
    endtask : toggle_pin
endmodule : epis_pin_model

// [verif/tb_top.sv]
/*
 * Self-checking bench of the external pin interrupt sense block.
 * Assumes the register map of epis_regs.svh and the wait-free APB slave of the block.
 */
`timescale 1ns/1ps
`include "epis_regs.svh"
module tb_top;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] w;
        logic [31:0] r;
    } epis_tb_row_t;

    logic        mclk_i, arst_n, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, wake;
    logic [1:0]  lines;
    logic [15:0] pins, vec;
    logic [3:0]  ack_r, req;
    int          n_mismatch, compares, n_wake;
    epis_tb_row_t rows [7] = '{
        '{`EPIS_OFS_SENSE, 32'hff, 32'h0f}, '{`EPIS_OFS_MASK_UPPER, 32'ha5, 32'ha5},
        '{`EPIS_OFS_MASK_LOWER, 32'h5a, 32'h5a}, '{`EPIS_OFS_LINE_EN, 32'h3, 32'h3},
        '{`EPIS_OFS_CHG_EN, 32'h3, 32'h3}, '{`EPIS_OFS_GLOBAL, 32'h1, 32'h1},
        '{`EPIS_OFS_SENSE, 32'h0, 32'h0}};

    epis_top u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .ext_lines_i(lines), .change_watch_pins_i(pins), .irq_ack_i(ack_r),
        .irq_req_o(req), .irq_vector_o(vec), .wake_o(wake));
    epis_pin_model u_pins (.mclk_i(mclk_i), .ext_lines_o(lines), .change_watch_pins_o(pins));

    // ==========================================================
    // Clock, wake monitor, watchdog
    // ==========================================================
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (wake === 1'b1) n_wake++;
    initial begin
        #80000;
        n_mismatch++;
        report_and_stop();
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge mclk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        // Waits for the slave; only the watchdog ends a hang
        do begin
            @(posedge mclk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pslverr", 32'(er), 32'(a > `EPIS_OFS_PIN_STATE || a[1:0] != 2'b00));
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r, x);
    endtask : rd_chk

    task automatic expect_req(input int b, input logic e);
        int n;
        n = 0;
        if (e) begin
            while (req[b] !== 1'b1 && n < 12) begin
                @(posedge mclk_i);
                n++;
            end
        end else repeat (8) @(posedge mclk_i);
        chk("irq_req", 32'(req[b]), 32'(e));
    endtask : expect_req

    task automatic ack(input int b);
        @(posedge mclk_i);
        ack_r <= 4'h1 << b;
        @(posedge mclk_i);
        ack_r <= 4'h0;
    endtask : ack

    task automatic report_and_stop();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        logic [31:0] d;
        logic        e;
        int          w0;
        {arst_n, psel, penable, pwrite, paddr, pwdata, ack_r} = '0;
        repeat (2) @(posedge mclk_i);
        arst_n <= 1'b1;
        rd_chk("sense", `EPIS_OFS_SENSE, 32'h0);
        rd_chk("mask_upper", `EPIS_OFS_MASK_UPPER, 32'h0);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].w);
            rd_chk("reg", rows[k].a, rows[k].r);
        end
        for (int i = 0; i < 2; i++) begin
            for (int m = 1; m < 4; m++) begin
                wr(`EPIS_OFS_SENSE, 32'(m << (2 * i)));
                wr(`EPIS_OFS_LINE_FLAG, 32'h3);
                u_pins.set_line(i, 1'b0);
                expect_req(i, m != 3);
                if (m != 3) chk("vector", 32'(vec), 32'(i ? `EPIS_VEC_LINE_B : `EPIS_VEC_LINE_A));
                ack(i);
                u_pins.set_line(i, 1'b1);
                expect_req(i, m != 2);
                ack(i);
                expect_req(i, 1'b0);
            end
        end
        wr(`EPIS_OFS_SENSE, 32'h0);
        u_pins.set_line(1, 1'b0);
        expect_req(1, 1'b1);
        rd_chk("line_flag", `EPIS_OFS_LINE_FLAG, 32'h0);
        chk("irq_req", 32'(req[1]), 32'h1);
        u_pins.set_line(1, 1'b1);
        expect_req(1, 1'b0);
        wr(`EPIS_OFS_GLOBAL, 32'h0);
        wr(`EPIS_OFS_SENSE, 32'h2);
        u_pins.set_line(0, 1'b0);
        expect_req(0, 1'b0);
        rd_chk("line_flag", `EPIS_OFS_LINE_FLAG, 32'h1);
        wr(`EPIS_OFS_GLOBAL, 32'h1);
        expect_req(0, 1'b1);
        wr(`EPIS_OFS_LINE_EN, 32'h2);
        expect_req(0, 1'b0);
        wr(`EPIS_OFS_LINE_FLAG, 32'h1);
        wr(`EPIS_OFS_LINE_EN, 32'h3);
        expect_req(0, 1'b0);
        u_pins.set_line(0, 1'b1);
        wr(`EPIS_OFS_MASK_UPPER, 32'h1);
        wr(`EPIS_OFS_MASK_LOWER, 32'h1);
        wr(`EPIS_OFS_CHG_FLAG, 32'h3);
        u_pins.toggle_pin(9);
        expect_req(3, 1'b0);
        w0 = n_wake;
        u_pins.toggle_pin(8);
        expect_req(3, 1'b1);
        chk("vector", 32'(vec), 32'(`EPIS_VEC_CHG_UPPER));
        chk("wake", 32'(n_wake > w0), 32'h1);
        ack(3);
        expect_req(3, 1'b0);
        u_pins.toggle_pin(0);
        expect_req(2, 1'b1);
        chk("vector", 32'(vec), 32'(`EPIS_VEC_CHG_LOWER));
        wr(`EPIS_OFS_CHG_FLAG, 32'h1);
        expect_req(2, 1'b0);
        u_pins.toggle_pin(1);
        expect_req(2, 1'b0);
        rd_chk("pin_state", `EPIS_OFS_PIN_STATE, 32'h0003_0303);
        apb(1'b0, 12'h024, 32'h0, d, e);
        chk("pslverr", 32'(e), 32'h1);
        chk("unmapped", d, 32'h0);
        wr(`EPIS_OFS_SENSE, 32'h5);
        @(posedge mclk_i);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk("irq_req", 32'(req), 32'h0);
        arst_n <= 1'b1;
        rd_chk("sense", `EPIS_OFS_SENSE, 32'h0);
        report_and_stop();
    end
endmodule : tb_top
